/* design/packet_uart.sv */
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module packet_uart import uart_pkg::*; #(
  parameter int LINES = 8,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  // Flexible I/O lines
  input wire logic [LINES-1:0] flex_in,
  output logic [LINES-1:0] flex_out,
  output logic [LINES-1:0] flex_oe_n
);
  localparam int LW = $clog2(LINES);

  logic [1:0] rs_q;
  logic rst_i_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_q <= 2'b00;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_i_n = rs_q[1];

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      lane_merge[8*i+:8] = sel[i] ? nw[8*i+:8] : old[8*i+:8];
    end
  endfunction

  state_t state_q, state_d;
  logic port_on_q, port_on_d, assigned_q, assigned_d, txd_q, txd_d, flush_q, flush_d;
  logic [LW-1:0] pin_off_q, pin_off_d;
  logic [15:0] div_q, div_d, stage_q, stage_d, resp_a_q, resp_a_d, resp_b_q, resp_b_d;
  logic [7:0] err_q, err_d, rcode_q, rcode_d, rlen_q, rlen_d;
  logic [5:0] left_q, left_d, done_q, done_d, cidx_q, cidx_d;
  logic [9:0] shift_q, shift_d;
  logic [3:0] bitn_q, bitn_d;
  logic [19:0] cyc_q, cyc_d, bit_cyc;
  logic [7:0] rbuf_q [RX_CHUNK];
  logic [7:0] rbuf_d [RX_CHUNK];
  logic [7:0] mem_q [256];
  logic [7:0] mem_d [256];
  logic [7:0] wp_q, wp_d, rp_q, rp_d;
  logic [8:0] cnt_q, cnt_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d, pins_w;
  logic req, tx_wr, wr, cmd_wr, link_ok, pop, push, flush_now;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready, rx_valid;
  logic [7:0] fifo_out_data, rx_data, code, len, arg;
  logic [LW-1:0] rx_idx;

  assign link_ok = port_on_q & assigned_q; // [R07]
  assign rx_idx = LW'(pin_off_q + 1'b1); // [R03]
  assign bit_cyc = bit_cycles(div_q); // [R08]

  // Bus side: a TXDATA write is held off while the FIFO is full.
  always_comb begin
    req = cyc_i & stb_i & ~ack_q;
    tx_wr = we_i & (adr_i[7:2] == ADDR_TXDATA) & sel_i[0];
    ack_d = req & (~tx_wr | fifo_in_ready);
    wr = ack_d & we_i;
    cmd_wr = wr & (adr_i[7:2] == ADDR_CMD) & (&sel_i);
    code = dat_i[7:0];
    len = dat_i[15:8];
    arg = dat_i[23:16];
    pins_w = lane_merge({{(32 - PIN_OFF_LSB - LW){1'b0}}, pin_off_q,
                         {(PIN_OFF_LSB - 1){1'b0}}, assigned_q}, dat_i, sel_i);
    dat_d = 32'h0;
    if (ack_d && !we_i) begin
      unique case (adr_i[7:2])
        ADDR_DIV: dat_d = {16'h0, stage_q};
        ADDR_STATUS: dat_d = {rcode_q, rlen_q, 5'h0, assigned_q, port_on_q,
                              state_q != ST_IDLE, err_q};
        ADDR_RESP0: dat_d = {16'h0, resp_a_q};
        ADDR_RESP1: dat_d = {16'h0, resp_b_q};
        ADDR_PINS: dat_d = 32'({pin_off_q, {(PIN_OFF_LSB - 1){1'b0}}, assigned_q});
        ADDR_FILL: dat_d = {23'h0, cnt_q};
        default: begin
          if (adr_i[7:5] == ADDR_RBUF[5:3]) begin
            for (int i = 0; i < 4; i++) begin
              dat_d[8*i+:8] = rbuf_q[{adr_i[4:2], 2'(i)}];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  stream_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .core_clk(core_clk),
    .rst_n(rst_i_n),
    .in_valid(req & tx_wr),
    .in_ready(fifo_in_ready),
    .in_data(dat_i[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  serial_rx rx_unit (
    .core_clk(core_clk),
    .rst_n(rst_i_n),
    .rxd(flex_in[rx_idx]),
    .enable(link_ok), // [R07]
    .bit_cyc(bit_cyc),
    .byte_valid(rx_valid),
    .byte_data(rx_data)
  );

  // Command sequencer, transmit shifter and read-out copy.
  always_comb begin
    state_d = state_q;
    port_on_d = port_on_q;
    assigned_d = assigned_q;
    pin_off_d = pin_off_q;
    div_d = div_q;
    stage_d = stage_q;
    err_d = err_q;
    rcode_d = rcode_q;
    rlen_d = rlen_q;
    resp_a_d = resp_a_q;
    resp_b_d = resp_b_q;
    left_d = left_q;
    done_d = done_q;
    shift_d = shift_q;
    bitn_d = bitn_q;
    cyc_d = cyc_q;
    cidx_d = cidx_q;
    flush_d = flush_q;
    rbuf_d = rbuf_q;
    pop = 1'b0;
    flush_now = 1'b0;
    fifo_out_ready = 1'b0;
    if (wr && adr_i[7:2] == ADDR_DIV) begin
      stage_d = 16'(lane_merge({16'h0, stage_q}, dat_i, sel_i));
    end
    if (wr && adr_i[7:2] == ADDR_PINS) begin
      assigned_d = pins_w[0];
      pin_off_d = pins_w[PIN_OFF_LSB+:LW];
    end
    unique case (state_q)
      ST_IDLE: begin
        // A command written while busy is dropped; STATUS shows busy.
        if (cmd_wr) begin
          rcode_d = code;
          err_d = ERR_NONE;
          if (code == CMD_CONFIG) begin // [R04]
            rlen_d = LEN_CONFIG;
            if (len != LEN_CONFIG) begin
              err_d = ERR_BAD_LEN;
            end else begin
              if (arg[OPT_UPDATE_BIT]) begin // [R05]
                port_on_d = arg[OPT_ENABLE_BIT]; // [R06]
                div_d = stage_q;
              end
              resp_a_d = {8'h00, arg[OPT_UPDATE_BIT], port_on_d, 6'h00}; // [R17]
              resp_b_d = div_d; // [R17]
            end
          end else if (code == CMD_TX) begin
            rlen_d = LEN_TX_RESP;
            done_d = 6'h00;
            resp_a_d = 16'h0;
            resp_b_d = {7'h0, cnt_q}; // [R11]
            if (arg > TX_MAX || len != 8'(9'h1 + ((9'(arg) + 9'h1) >> 1))) begin // [R09]
              err_d = ERR_BAD_LEN;
            end else if (!link_ok) begin
              err_d = ERR_NOT_READY; // [R07]
            end else if (arg != 8'h00) begin
              left_d = arg[5:0]; // [R10]
              state_d = ST_TX_WAIT;
            end
          end else if (code == CMD_RX) begin
            rlen_d = LEN_RX_RESP;
            if (len != LEN_RX_CMD) begin
              err_d = ERR_BAD_LEN;
            end else begin
              resp_a_d = {7'h0, cnt_q}; // [R14]
              flush_d = arg != 8'h00;
              cidx_d = 6'h00;
              state_d = ST_RX_COPY;
            end
          end else begin
            rlen_d = 8'h00;
            err_d = ERR_BAD_CMD;
          end
        end
      end
      ST_TX_WAIT: begin
        fifo_out_ready = 1'b1;
        if (fifo_out_valid) begin
          shift_d = {1'b1, fifo_out_data, 1'b0}; // [R01]
          bitn_d = 4'h0;
          cyc_d = 20'h0;
          state_d = ST_TX_SHIFT;
        end
      end
      ST_TX_SHIFT: begin
        if (cyc_q == bit_cyc - 20'h1) begin
          cyc_d = 20'h0;
          shift_d = {1'b1, shift_q[9:1]};
          bitn_d = bitn_q + 4'h1;
          if (bitn_q == FRAME_BITS - 4'h1) begin
            done_d = done_q + 6'h01; // [R10]
            left_d = left_q - 6'h01;
            resp_a_d = {10'h0, done_d}; // [R11]
            state_d = (left_q == 6'h01) ? ST_IDLE : ST_TX_WAIT;
          end
        end else begin
          cyc_d = cyc_q + 20'h1;
        end
      end
      ST_RX_COPY: begin
        pop = 9'(cidx_q) < resp_a_q[8:0]; // [R12]
        rbuf_d[5'(cidx_q)] = pop ? mem_q[rp_q] : 8'h00; // [R16]
        cidx_d = cidx_q + 6'h01;
        if (cidx_q == 6'(RX_CHUNK - 1)) begin
          flush_now = flush_q; // [R13]
          state_d = ST_IDLE;
        end
      end
    endcase
    txd_d = (state_d == ST_TX_SHIFT) ? shift_d[0] : 1'b1; // [R02]
  end

  always_ff @(posedge core_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      state_q <= ST_IDLE;
      port_on_q <= 1'b0;
      assigned_q <= 1'b0;
      pin_off_q <= '0;
      txd_q <= 1'b1;
      flush_q <= 1'b0;
      div_q <= RESET_DIVISOR;
      stage_q <= RESET_DIVISOR;
      resp_a_q <= 16'h0;
      resp_b_q <= 16'h0;
      err_q <= ERR_NONE;
      rcode_q <= 8'h00;
      rlen_q <= 8'h00;
      left_q <= 6'h00;
      done_q <= 6'h00;
      cidx_q <= 6'h00;
      shift_q <= 10'h3FF;
      bitn_q <= 4'h0;
      cyc_q <= 20'h0;
      for (int i = 0; i < RX_CHUNK; i++) begin
        rbuf_q[i] <= 8'h00;
      end
    end else begin
      state_q <= state_d;
      port_on_q <= port_on_d;
      assigned_q <= assigned_d;
      pin_off_q <= pin_off_d;
      txd_q <= txd_d;
      flush_q <= flush_d;
      div_q <= div_d;
      stage_q <= stage_d;
      resp_a_q <= resp_a_d;
      resp_b_q <= resp_b_d;
      err_q <= err_d;
      rcode_q <= rcode_d;
      rlen_q <= rlen_d;
      left_q <= left_d;
      done_q <= done_d;
      cidx_q <= cidx_d;
      shift_q <= shift_d;
      bitn_q <= bitn_d;
      cyc_q <= cyc_d;
      rbuf_q <= rbuf_d;
    end
  end

  // Receive buffer: a full buffer drops the new character, never an old one.
  always_comb begin
    push = rx_valid & (cnt_q != RXBUF_DEPTH); // [R15]
    mem_d = mem_q;
    wp_d = wp_q + 8'(push);
    rp_d = rp_q + 8'(pop);
    cnt_d = cnt_q + 9'(push) - 9'(pop);
    if (push) begin
      mem_d[wp_q] = rx_data; // [R12]
    end
    if (flush_now) begin
      rp_d = wp_q; // [R13]
      cnt_d = 9'(push);
    end
  end

  always_ff @(posedge core_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      for (int i = 0; i < 256; i++) begin
        mem_q[i] <= 8'h00;
      end
      wp_q <= 8'h00;
      rp_q <= 8'h00;
      cnt_q <= 9'h000;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Only the transmit line is driven; the receive line stays an input.
  always_comb begin
    flex_out = '1;
    flex_oe_n = '1;
    if (link_ok) begin
      flex_out[pin_off_q] = txd_q; // [R03]
      flex_oe_n[pin_off_q] = 1'b0;
    end
  end
endmodule

/* include/uart_pkg.sv */
// What this block does
// [R01] Characters are 8 data, no parity, 1 stop.
// [R02] Lines idle high; start bit low.
// [R03] TX on first free line, RX next.
// [R04] Configure is code 0x14, length 0x02.
// [R05] Option bit 7 stores settings, else report.
// [R06] Option bit 6 turns the port on.
// [R07] No data moves until pins assigned.
// [R08] Divisor equals 26 - 48e6/(2*rate).
// [R09] Host pads odd payload; length is half.
// [R10] Send exactly 0-56 bytes, in order.
// [R11] TX answer gives sent and held counts.
// [R12] 256-byte RX FIFO; read takes 32 oldest.
// [R13] Nonzero flush empties whole RX buffer.
// [R14] Read answer gives fill before removal.
// [R15] Full RX buffer drops new characters.
// [R16] Read answer pads unused bytes with zero.
// [R17] Configure answer echoes options and divisor.
package uart_pkg;
  localparam logic [7:0] CMD_CONFIG = 8'h14;
  localparam logic [7:0] CMD_TX = 8'h15;
  localparam logic [7:0] CMD_RX = 8'h16;
  localparam logic [7:0] LEN_CONFIG = 8'h02;
  localparam logic [7:0] LEN_RX_CMD = 8'h01;
  localparam logic [7:0] LEN_TX_RESP = 8'h02;
  localparam logic [7:0] LEN_RX_RESP = 8'h11;
  localparam int OPT_UPDATE_BIT = 7;
  localparam int OPT_ENABLE_BIT = 6;
  localparam logic [15:0] DIV_OFFSET = 16'h001A;
  localparam logic [15:0] RESET_DIVISOR = 16'hF656;
  localparam longint REF_HZ = 48000000;
  localparam longint CLK_HZ = 25000000;
  localparam logic [7:0] TX_MAX = 8'h38;
  localparam int RX_CHUNK = 32;
  localparam logic [8:0] RXBUF_DEPTH = 9'h100;
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_BAD_CMD = 8'h01;
  localparam logic [7:0] ERR_BAD_LEN = 8'h02;
  localparam logic [7:0] ERR_NOT_READY = 8'h03;
  localparam logic [5:0] ADDR_CMD = 6'h00;
  localparam logic [5:0] ADDR_DIV = 6'h01;
  localparam logic [5:0] ADDR_TXDATA = 6'h02;
  localparam logic [5:0] ADDR_STATUS = 6'h03;
  localparam logic [5:0] ADDR_RESP0 = 6'h04;
  localparam logic [5:0] ADDR_RESP1 = 6'h05;
  localparam logic [5:0] ADDR_PINS = 6'h06;
  localparam logic [5:0] ADDR_FILL = 6'h07;
  localparam logic [5:0] ADDR_RBUF = 6'h10;
  localparam int PIN_OFF_LSB = 4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TX_WAIT = 2'b01,
    ST_TX_SHIFT = 2'b11,
    ST_RX_COPY = 2'b10
  } state_t;

  // Divisor counts half bits of the 48 MHz reference; scaled to the core clock.
  function automatic logic [19:0] bit_cycles(input logic [15:0] div);
    logic [63:0] t;
    t = 64'(16'(DIV_OFFSET - div)) * 64'(2 * CLK_HZ) / 64'(REF_HZ); // [R08]
    bit_cycles = (t == 64'h0) ? 20'h00001 : 20'(t);
  endfunction
endpackage

/* design/stream_fifo.sv */
`timescale 1ns/1ps
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready = cnt_q != FULL;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];

  always_comb begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d = step(wp_q);
    end
    if (pop) begin
      rp_d = step(rp_q);
    end
    cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

/* design/serial_rx.sv */
`timescale 1ns/1ps
module serial_rx import uart_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Line and timing
  input wire logic rxd,
  input wire logic enable,
  input wire logic [19:0] bit_cyc,
  // Received character
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [3:0] idx_q, idx_d;
  logic [19:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic val_q, val_d;

  assign byte_valid = val_q;
  assign byte_data = sh_q;

  // Idle while idx is zero; sampling lands mid-bit after a half-bit wait.
  always_comb begin
    idx_d = idx_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    val_d = 1'b0;
    if (idx_q == 4'h0) begin
      if (enable && !rxd) begin // [R02]
        idx_d = 4'h1;
        cnt_d = {1'b0, bit_cyc[19:1]};
      end
    end else if (cnt_q != 20'h0) begin
      cnt_d = cnt_q - 20'h1;
    end else begin
      cnt_d = bit_cyc - 20'h1;
      idx_d = idx_q + 4'h1;
      if (idx_q == 4'h1 && rxd) begin
        idx_d = 4'h0;
      end else if (idx_q >= 4'h2 && idx_q < FRAME_BITS) begin
        sh_d = {rxd, sh_q[7:1]}; // [R01]
      end else if (idx_q == FRAME_BITS) begin
        idx_d = 4'h0;
        val_d = rxd; // [R01]
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 4'h0;
      cnt_q <= 20'h0;
      sh_q <= 8'h00;
      val_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      val_q <= val_d;
    end
  end
endmodule

/* verif/packet_uart_properties.sv */
`timescale 1ns/1ps
module packet_uart_properties import uart_pkg::*; #(
  parameter int LINES = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Flexible I/O lines
  input wire logic [LINES-1:0] flex_in,
  input wire logic [LINES-1:0] flex_out,
  input wire logic [LINES-1:0] flex_oe_n
);
  // Bit period that follows from the divisor the bench programs.
  localparam int BIT = 50;
  localparam int MID_STOP = 475;
  logic txl;
  logic [9:0] fcnt_d;
  logic [9:0] fcnt_q;
  // Undriven lines sit high, so the transmit level is the AND of all lines.
  assign txl = &flex_out;
  always_comb begin
    fcnt_d = 10'h000;
    if (fcnt_q == 10'h000) fcnt_d = {9'h000, ~txl};
    else if (fcnt_q < 10'(MID_STOP)) fcnt_d = fcnt_q + 10'h001;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) fcnt_q <= 10'h000;
    else fcnt_q <= fcnt_d;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence start_bit_s;
    (!txl) [*8];
  endsequence
  start_hold_a: assert property (fcnt_q == 10'h001 |-> start_bit_s)
    else $error("start bit too short");
  start_mid_a: assert property (fcnt_q == 10'(BIT / 2) |-> !txl)
    else $error("start bit not low at mid bit");
  stop_high_a: assert property (fcnt_q == 10'(MID_STOP) |-> txl)
    else $error("stop bit not high");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  read_answer_a: assert property (cyc_i && stb_i && !we_i && !ack_o |=> ack_o)
    else $error("read not answered next cycle");
  dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  one_driver_a: assert property ($onehot0(~flex_oe_n))
    else $error("more than one line driven");
  undriven_high_a: assert property (&(flex_out | ~flex_oe_n))
    else $error("undriven line not high");
  // The enabling write lands on the same edge as its ack, so the ack stands now.
  drive_cause_a: assert property ($fell(&flex_oe_n) |->
    (ack_o && we_i) || $past(ack_o && we_i))
    else $error("line driven without a register write");
endmodule

/* verif/serial_peer.sv */
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT = 50
) (
  // Clock
  input wire logic core_clk,
  // Serial lines
  input wire logic txd,
  output logic rxd
);
  logic [7:0] got_q[$];
  logic [7:0] sh;
  initial rxd = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    @(posedge core_clk);
    rxd <= 1'b0;
    repeat (BIT) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (BIT) @(posedge core_clk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge core_clk);
  endtask
  // Sampling at mid bit tolerates a few cycles of skew; a bad stop bit drops the byte.
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge core_clk);
      sh[i] = txd;
    end
    repeat (BIT) @(posedge core_clk);
    if (txd === 1'b1) got_q.push_back(sh);
  end
endmodule

/* verif/packet_uart_tb_top.sv */
`timescale 1ns/1ps
module packet_uart_tb_top import uart_pkg::*;;
  localparam int RATE = 500000;
  localparam int BIT = 25000000 / RATE;
  localparam logic [15:0] DIV = 16'(26 - 48000000 / (2 * RATE));
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [5:0] hi_in = 6'h00;
  logic [31:0] dat_o;
  logic ack_o;
  logic [7:0] flex_in;
  logic [7:0] flex_out;
  logic [7:0] flex_oe_n;
  logic txd;
  logic rxd;
  logic [31:0] q;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 32'h50827F39;
  always #20 core_clk = ~core_clk;
  // A released transmit line is pulled high.
  assign txd = flex_oe_n[0] ? 1'b1 : flex_out[0];
  assign flex_in = {hi_in, rxd, txd};
  packet_uart packet_uart_i (.core_clk(core_clk), .rst_n(rst_n), .adr_i(adr), .dat_i(dat),
    .dat_o(dat_o), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack_o),
    .flex_in(flex_in), .flex_out(flex_out), .flex_oe_n(flex_oe_n));
  serial_peer #(.BIT(BIT)) serial_peer_i (.core_clk(core_clk), .txd(txd), .rxd(rxd));
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    dat <= d;
    sel <= 4'hF;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20000);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20000) n_errors++;
  endtask
  task automatic cmd(input logic [7:0] code, input logic [7:0] len, input logic [7:0] arg);
    wb(1'b1, ADDR_CMD, {8'h00, arg, len, code});
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      wb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (q[8] !== 1'b0 && n < 4000);
    if (n >= 4000) n_errors++;
  endtask
  task automatic peer_send(input int n);
    logic [7:0] b;
    repeat (n) begin
      b = 8'($random(seed));
      exp_q.push_back(b);
      serial_peer_i.send_byte(b);
    end
  endtask
  task automatic rx_read(input logic [7:0] flush, input int n);
    logic [31:0] w;
    cmd(CMD_RX, LEN_RX_CMD, flush);
    wait_idle();
    wb(1'b0, ADDR_RESP0, 32'h0);
    chk(q, 32'(n));
    for (int k = 0; k < 8; k++) begin
      w = 32'h0;
      for (int b = 0; b < 4; b++) if (exp_q.size() > 0) w[8*b +: 8] = exp_q.pop_front();
      wb(1'b0, ADDR_RBUF + 6'(k), 32'h0);
      chk(q, w);
    end
    if (flush != 8'h00) exp_q.delete();
    wb(1'b0, ADDR_FILL, 32'h0);
    chk(q, 32'(exp_q.size()));
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] tx_q[$];
    logic [7:0] b;
    hi_in = 6'($random(seed));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(32'(flex_out), 32'hFF);
    chk(32'(flex_oe_n), 32'hFF);
    wb(1'b0, ADDR_DIV, 32'h0);
    chk(q, 32'(RESET_DIVISOR));
    wb(1'b0, 6'h3F, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, ADDR_DIV, 32'(DIV));
    cmd(CMD_CONFIG, LEN_CONFIG, 8'h40);
    wb(1'b0, ADDR_RESP0, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, ADDR_RESP1, 32'h0);
    chk(q, 32'(RESET_DIVISOR));
    cmd(CMD_CONFIG, LEN_CONFIG, 8'hC0);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h1402_0200);
    wb(1'b0, ADDR_RESP0, 32'h0);
    chk(q, 32'h0000_00C0);
    wb(1'b0, ADDR_RESP1, 32'h0);
    chk(q, 32'(DIV));
    cmd(CMD_TX, 8'h02, 8'h01);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(q & 32'hFF, 32'(ERR_NOT_READY));
    wb(1'b1, ADDR_PINS, 32'h1);
    @(negedge core_clk);
    chk(32'(flex_oe_n), 32'hFE);
    wb(1'b0, ADDR_PINS, 32'h0);
    chk(q, 32'h1);
    cmd(CMD_TX, 8'h03, 8'h01);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(q & 32'hFF, 32'(ERR_BAD_LEN));
    cmd(8'h33, 8'h01, 8'h00);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(q & 32'hFF, 32'(ERR_BAD_CMD));
    cmd(CMD_TX, 8'h01, 8'h00);
    wb(1'b0, ADDR_RESP0, 32'h0);
    chk(q, 32'h0);
    // Eight bytes fill the queue; the ninth takes the slot freed by the first pop, only the tenth waits.
    for (int i = 0; i < 10; i++) begin
      b = 8'($random(seed));
      tx_q.push_back(b);
      wb(1'b1, ADDR_TXDATA, {24'h0, b});
      if (i == 7) cmd(CMD_TX, 8'h06, 8'h0A);
    end
    wait_idle();
    wb(1'b0, ADDR_RESP0, 32'h0);
    chk(q, 32'h0A);
    wb(1'b0, ADDR_RESP1, 32'h0);
    chk(q, 32'h0);
    repeat (BIT) @(posedge core_clk);
    chk(32'(serial_peer_i.got_q.size()), 32'hA);
    foreach (tx_q[i]) chk(32'(serial_peer_i.got_q[i]), 32'(tx_q[i]));
    peer_send(3);
    wb(1'b0, ADDR_FILL, 32'h0);
    chk(q, 32'h3);
    rx_read(8'h00, 3);
    peer_send(34);
    rx_read(8'h01, 34);
    tally_and_finish();
  end
endmodule
bind packet_uart packet_uart_properties #(.LINES(LINES)) packet_uart_properties_i (
  .core_clk(core_clk), .rst_n(rst_n), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
  .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .flex_in(flex_in), .flex_out(flex_out), .flex_oe_n(flex_oe_n));
